/* rtl/stp_defs.vh */
// Constants for the SMBus register port of the temperature monitor.
// Assumes a 25 MHz system clock and byte-wide registers behind one address.
`ifndef STP_DEFS_VH
`define STP_DEFS_VH

// Bus slave address, arbitrary value for this build.
`define STP_SLAVE_ADDR   7'h2a

// Register offsets as seen by the command pointer.
`define STP_GP_COUNT     16
`define STP_GP_LAST      8'h0f
`define STP_CFG1_IDX     4'h1
`define STP_TEMP_BASE    8'h10
`define STP_TEMP_LAST    8'h16
`define STP_TEMP_CH1     8'h11
`define STP_EXT_ADDR     8'h17
`define STP_CH1          3'h1
`define STP_NUM_CH       7

// Field positions and values.
`define STP_CFG1_TODIS   5
`define STP_PTR_RST      8'h00
`define STP_REG_RST      8'h00
`define STP_UNMAPPED     8'h00
`define STP_HI_MAX       8'h7f
`define STP_HI_MIN       8'h00
`define STP_HI_OPEN      8'hff
`define STP_HI_SHORT     8'hee
`define STP_EXT_LOW      5'h00

// Timing: SMBus timeout in ms and the clock rate in kHz.
`define STP_TOUT_MS      37
`define STP_CLK_KHZ      25000
`define STP_TOUT_CYC     (`STP_TOUT_MS * `STP_CLK_KHZ)
`define STP_TOUT_W       24

`endif

/* rtl/stp_smbus.v */
// SMBus slave register port of a multichannel temperature monitor.
// Assumes SCL and SDA arrive synchronous to clk_sys_i and that the
// conversion engine delivers one result per upd_i pulse.
`timescale 1ns/100ps
`include "stp_defs.vh"

module stp_smbus
#(
    parameter SLAVE_ADDR = `STP_SLAVE_ADDR,
    parameter TOUT_CYC   = `STP_TOUT_CYC,
    parameter SHORT_CODE = `STP_HI_SHORT
)
(
    input  wire        clk_sys_i,
    input  wire        nrst_i,
    input  wire        ce_i,
    input  wire        scl_i,
    input  wire        sda_i,
    output reg         sda_o,
    output reg         sda_oe_o,
    input  wire        upd_i,
    input  wire [2:0]  upd_ch_i,
    input  wire [12:0] upd_temp_i,
    input  wire        upd_open_i,
    input  wire        upd_short_i,
    output reg  [7:0]  cmd_ptr_o,
    output reg  [7:0]  cfg1_o,
    output reg         hold_o
);

    // ========================================================================
    // Protocol states
    // ========================================================================
    localparam [3:0] ST_IDLE  = 4'h0;
    localparam [3:0] ST_ADDR  = 4'h1;
    localparam [3:0] ST_RX    = 4'h2;
    localparam [3:0] ST_ACK   = 4'h3;
    localparam [3:0] ST_TX    = 4'h4;
    localparam [3:0] ST_MACK  = 4'h5;
    localparam [3:0] ST_WAIT  = 4'h6;
    localparam [`STP_TOUT_W-1:0] TOUT_LIM = TOUT_CYC[`STP_TOUT_W-1:0];

    reg  [3:0]  state;
    reg  [3:0]  next_state;
    reg         scl_q;
    reg         sda_q;
    reg  [7:0]  shreg;
    reg  [2:0]  bcnt;
    reg         byte_done;
    reg         rd_mode;
    reg  [1:0]  byte_idx;
    reg  [`STP_TOUT_W-1:0] bus_tcnt;
    reg  [`STP_TOUT_W-1:0] hold_tcnt;
    reg  [7:0]  ext_reg;
    reg  [7:0]  rd_data;
    reg  [7:0]  hi_code;
    reg  [7:0]  ext_code;

    wire        scl_rise = scl_i & ~scl_q;
    wire        scl_fall = ~scl_i & scl_q;
    wire        start_c  = scl_i & scl_q & sda_q & ~sda_i;
    wire        stop_c   = scl_i & scl_q & ~sda_q & sda_i;
    wire        tout_en  = ~cfg1_o[`STP_CFG1_TODIS];
    wire [127:0] gp_flat;
    wire [55:0]  hi_flat;
    wire        wr_strobe;

    // ========================================================================
    // Result formatting
    // ========================================================================
    // Integer part in [12:3], signed; fraction in [2:0] eighths.
    always @*
    begin
        if (upd_open_i)
            hi_code = `STP_HI_OPEN;
        else if (upd_short_i)
            hi_code = SHORT_CODE;
        else if (upd_temp_i[12])
            hi_code = `STP_HI_MIN;
        else if (upd_temp_i[11:10] != 2'b00)
            hi_code = `STP_HI_MAX;
        else
            hi_code = upd_temp_i[10:3];
    end

    // Fraction is only meaningful when the integer part was not clamped.
    always @*
    begin
        if (upd_open_i | upd_short_i | upd_temp_i[12] | (upd_temp_i[11:10] != 2'b00))
            ext_code = {3'b000, `STP_EXT_LOW};
        else
            ext_code = {upd_temp_i[2:0], `STP_EXT_LOW};
    end

    // ========================================================================
    // Register storage
    // ========================================================================
    assign wr_strobe = ce_i & (state == ST_RX) & scl_fall & byte_done & ~rd_mode
                       & (byte_idx == 2'd1);

    genvar gi;
    generate
        // Host-writable bytes: thresholds, configuration and masks.
        for (gi = 0; gi < `STP_GP_COUNT; gi = gi + 1)
        begin : g_gp
            reg [7:0] val;
            always @(posedge clk_sys_i)
            begin
                if (!nrst_i)
                    val <= `STP_REG_RST;
                else if (wr_strobe && cmd_ptr_o == gi)
                    val <= shreg;
            end
            assign gp_flat[gi*8 +: 8] = val;
        end
        // Main temperature bytes, channel 0 is the local sensor.
        for (gi = 0; gi < `STP_NUM_CH; gi = gi + 1)
        begin : g_hi
            reg [7:0] val;
            always @(posedge clk_sys_i)
            begin
                if (!nrst_i)
                    val <= `STP_REG_RST;
                else if (ce_i && upd_i && upd_ch_i == gi && !(gi == 1 && hold_o))
                    val <= hi_code;
            end
            assign hi_flat[gi*8 +: 8] = val;
        end
    endgenerate

    // Extended byte follows channel 1 conversions.
    always @(posedge clk_sys_i)
    begin
        if (!nrst_i)
            ext_reg <= `STP_REG_RST;
        else if (ce_i && upd_i && upd_ch_i == `STP_CH1)
            ext_reg <= ext_code;
    end

    // Read multiplexer over the whole pointer space.
    always @*
    begin
        if (cmd_ptr_o <= `STP_GP_LAST)
            rd_data = gp_flat[cmd_ptr_o[3:0]*8 +: 8];
        else if (cmd_ptr_o >= `STP_TEMP_BASE && cmd_ptr_o <= `STP_TEMP_LAST)
            rd_data = hi_flat[cmd_ptr_o[2:0]*8 +: 8];
        else if (cmd_ptr_o == `STP_EXT_ADDR)
            rd_data = ext_reg;
        else
            rd_data = `STP_UNMAPPED;
    end

    // Configuration 1 copy, drives the timeout disable.
    always @(posedge clk_sys_i)
    begin
        if (!nrst_i)
            cfg1_o <= `STP_REG_RST;
        else if (ce_i)
            cfg1_o <= gp_flat[`STP_CFG1_IDX*8 +: 8];
    end

    // ========================================================================
    // Bus sequencer
    // ========================================================================
    // Next state from line events.
    always @*
    begin
        next_state = state;
        case (state)
            ST_IDLE:  next_state = ST_IDLE;
            ST_ADDR:  if (scl_fall && byte_done)
                          next_state = (shreg[7:1] == SLAVE_ADDR) ? ST_ACK : ST_WAIT;
            ST_RX:    if (scl_fall && byte_done)
                          next_state = (byte_idx < 2'd2) ? ST_ACK : ST_WAIT;
            ST_ACK:   if (scl_fall)
                          next_state = rd_mode ? ST_TX : ST_RX;
            ST_TX:    if (scl_fall && byte_done)
                          next_state = ST_MACK;
            ST_MACK:  if (scl_rise)
                          next_state = sda_i ? ST_WAIT : ST_TX;
            ST_WAIT:  next_state = ST_WAIT;
            default:  next_state = ST_IDLE;
        endcase
        if (start_c)
            next_state = ST_ADDR;
        else if (stop_c || (tout_en && bus_tcnt >= TOUT_LIM))
            next_state = ST_IDLE;
    end

    // Main sequencer, shift register and the open-drain data driver.
    always @(posedge clk_sys_i)
    begin
        if (!nrst_i)
        begin
            state     <= ST_IDLE;
            scl_q     <= 1'b1;
            sda_q     <= 1'b1;
            shreg     <= 8'h00;
            bcnt      <= 3'h0;
            byte_done <= 1'b0;
            rd_mode   <= 1'b0;
            byte_idx  <= 2'd0;
            sda_o     <= 1'b0;
            sda_oe_o  <= 1'b0;
            cmd_ptr_o <= `STP_PTR_RST;
        end
        else if (ce_i)
        begin
            scl_q <= scl_i;
            sda_q <= sda_i;
            state <= next_state;
            sda_o <= 1'b0;
            if (start_c)
            begin
                bcnt      <= 3'h0;
                byte_done <= 1'b0;
                byte_idx  <= 2'd0;
                sda_oe_o  <= 1'b0;
            end
            else if (next_state == ST_IDLE || next_state == ST_WAIT)
                sda_oe_o <= 1'b0;
            else
            begin
                // Sample on rising edges while receiving.
                if (scl_rise && (state == ST_ADDR || state == ST_RX))
                begin
                    shreg     <= {shreg[6:0], sda_i};
                    bcnt      <= bcnt + 3'h1;
                    byte_done <= (bcnt == 3'h7);
                end
                // End of a received byte: acknowledge it.
                if (scl_fall && byte_done && (state == ST_ADDR || state == ST_RX))
                begin
                    sda_oe_o  <= 1'b1;
                    byte_done <= 1'b0;
                    if (state == ST_ADDR)
                        rd_mode <= shreg[0];
                    else
                        byte_idx <= byte_idx + 2'd1;
                    if (state == ST_RX && byte_idx == 2'd0)
                        cmd_ptr_o <= shreg;
                end
                // Leave the acknowledge slot.
                if (scl_fall && state == ST_ACK)
                begin
                    if (rd_mode)
                    begin
                        shreg    <= {rd_data[6:0], 1'b0};
                        sda_oe_o <= ~rd_data[7];
                        bcnt     <= 3'h1;
                    end
                    else
                    begin
                        sda_oe_o <= 1'b0;
                        bcnt     <= 3'h0;
                    end
                end
                // Shift the next transmit bit out on each falling edge; the edge after bit 0 releases SDA.
                if (scl_fall && state == ST_TX)
                begin
                    if (byte_done)
                    begin
                        sda_oe_o  <= 1'b0;
                        byte_done <= 1'b0;
                    end
                    else
                    begin
                        sda_oe_o <= ~shreg[7];
                        shreg    <= {shreg[6:0], 1'b0};
                        bcnt     <= bcnt + 3'h1;
                        byte_done <= (bcnt == 3'h7); // Bit 0 leaves now.
                    end
                end
                // Master acknowledged: repeat the byte, pointer unchanged.
                if (scl_rise && state == ST_MACK && !sda_i)
                begin
                    shreg <= rd_data;
                    bcnt  <= 3'h0;
                end
            end
        end
    end

    // ========================================================================
    // Timeouts and high-byte hold
    // ========================================================================
    // Clock-low timeout returns the port to idle.
    always @(posedge clk_sys_i)
    begin
        if (!nrst_i)
            bus_tcnt <= {`STP_TOUT_W{1'b0}};
        else if (ce_i)
        begin
            if (!tout_en || scl_i || state == ST_IDLE)
                bus_tcnt <= {`STP_TOUT_W{1'b0}};
            else if (bus_tcnt < TOUT_LIM)
                bus_tcnt <= bus_tcnt + 1'b1;
        end
    end

    // Hold is set by an extended read, cleared by a channel 1 high-byte read.
    always @(posedge clk_sys_i)
    begin
        if (!nrst_i)
        begin
            hold_o    <= 1'b0;
            hold_tcnt <= {`STP_TOUT_W{1'b0}};
        end
        else if (ce_i)
        begin
            if (scl_fall && state == ST_ACK && rd_mode && cmd_ptr_o == `STP_EXT_ADDR)
            begin
                hold_o    <= 1'b1;
                hold_tcnt <= {`STP_TOUT_W{1'b0}};
            end
            else if (scl_fall && state == ST_ACK && rd_mode && cmd_ptr_o == `STP_TEMP_CH1)
                hold_o <= 1'b0;
            else if (hold_o && tout_en)
            begin
                if (hold_tcnt >= TOUT_LIM - 1)
                    hold_o <= 1'b0;
                else
                    hold_tcnt <= hold_tcnt + 1'b1;
            end
        end
    end

endmodule

/* tb/stp_smbus_properties.sv */
// Checker for the SMBus register port, bound to every stp_smbus.
// Assumes ce_i is only dropped while no hold is pending.
`timescale 1ns/100ps
module stp_smbus_properties
#(
    parameter TOUT_CYC = 200
)
(
    input wire       clk_sys_i,
    input wire       nrst_i,
    input wire       scl_i,
    input wire       sda_o,
    input wire       sda_oe_o,
    input wire [7:0] cmd_ptr_o,
    input wire [7:0] cfg1_o,
    input wire       hold_o
);
    // ==========================================
    // Port relations
    int cnt;
    default clocking cb @(posedge clk_sys_i); endclocking
    default disable iff (!nrst_i);
    // Counts cycles of a hold that may time out.
    always @(posedge clk_sys_i)
        if (!nrst_i || !hold_o || cfg1_o[5])
            cnt <= 0;
        else
            cnt <= cnt + 1;
    AST_RST_CLEAR: assert property (disable iff (1'b0)
        !nrst_i |=> cmd_ptr_o == 8'h00 && cfg1_o == 8'h00 && !hold_o && !sda_oe_o)
        else $error("Bad reset state.");
    AST_SDA_ZERO: assert property (sda_o == 1'b0) else $error("SDA value not low.");
    AST_OE_SCL_HI: assert property (scl_i && $past(scl_i) |-> $stable(sda_oe_o))
        else $error("SDA moved with SCL high.");
    AST_OE_AFTER_FALL: assert property ($changed(sda_oe_o) |-> !$past(scl_i))
        else $error("SDA moved outside SCL low.");
    AST_OE_STANDS: assert property ($rose(sda_oe_o) |-> sda_oe_o [*3])
        else $error("SDA pull too short.");
    AST_PTR_SLOT: assert property ($changed(cmd_ptr_o) |-> !scl_i && !$past(scl_i))
        else $error("Pointer moved outside SCL low.");
    AST_CFG_SLOT: assert property ($changed(cfg1_o) |-> !$past(scl_i))
        else $error("Register moved outside SCL low.");
    AST_HOLD_FALL: assert property ($rose(hold_o) |-> !$past(scl_i))
        else $error("Hold set outside SCL low.");
    AST_HOLD_TOUT: assert property (cnt <= TOUT_CYC + 1)
        else $error("Hold outlived the timeout.");
    AST_HOLD_KEEP: assert property ($fell(hold_o) |-> !$past(scl_i) || !$past(cfg1_o[5]))
        else $error("Hold dropped with timeout disabled.");
    COV_HOLD: cover property ($rose(hold_o));
    COV_TODIS: cover property ($rose(cfg1_o[5]));
    COV_PTR: cover property ($changed(cmd_ptr_o));
endmodule
bind stp_smbus stp_smbus_properties #(.TOUT_CYC(TOUT_CYC)) u_prop (.clk_sys_i(clk_sys_i),
    .nrst_i(nrst_i), .scl_i(scl_i), .sda_o(sda_o), .sda_oe_o(sda_oe_o),
    .cmd_ptr_o(cmd_ptr_o), .cfg1_o(cfg1_o), .hold_o(hold_o));

/* tb/stp_host_model.sv */
// Behavioural SMBus host master for the register port bench.
// Assumes SDA is open drain with a pull-up resolved by the bench.
`timescale 1ns/100ps
module stp_host_model
(
    input  wire clk_sys_i,
    input  wire sda_line_i,
    output reg  scl_o,
    output reg  sda_pull_o
);
    // ==========================================
    // Bus phases, each level held four clocks
    logic r;
    // Idle bus: SCL high, SDA released.
    initial
    begin
        scl_o = 1'b1;
        sda_pull_o = 1'b0;
    end
    task wt;
        repeat (4) @(negedge clk_sys_i);
    endtask
    task bitx(input logic b, output logic q);
        sda_pull_o = !b;
        wt;
        scl_o = 1'b1;
        wt;
        q = sda_line_i;
        scl_o = 1'b0;
    endtask
    task start;
        sda_pull_o = 1'b0;
        wt;
        scl_o = 1'b1;
        wt;
        sda_pull_o = 1'b1;
        wt;
        scl_o = 1'b0;
        wt;
    endtask
    task stop;
        sda_pull_o = 1'b1;
        wt;
        scl_o = 1'b1;
        wt;
        sda_pull_o = 1'b0;
        wt;
    endtask
    // Sends a byte MSB first; ack is high when the slave pulled low.
    task wr(input logic [7:0] v, output logic ack);
        for (int k = 7; k >= 0; k--)
            bitx(v[k], r);
        bitx(1'b1, r);
        ack = !r;
    endtask
    task rd(input logic last, output logic [7:0] v);
        for (int k = 7; k >= 0; k--)
            bitx(1'b1, v[k]);
        bitx(last, r);
    endtask
endmodule

/* tb/stp_smbus_tb_top.sv */
// Self-checking bench for stp_smbus with a host model on SCL and SDA.
// Assumes a short timeout parameter so holds expire quickly.
`timescale 1ns/100ps
`include "stp_defs.vh"
module stp_smbus_tb_top;
    // ==========================================
    // Signals, design and host
    localparam TOUT = 200;
    typedef struct packed {logic [2:0] ch; logic [12:0] t; logic op; logic sh;
        logic [7:0] hi; logic [7:0] ext;} stp_row_t;
    stp_row_t rows [10] = '{'{0, 13'h00c8, 0, 0, 8'h19, 0}, '{1, 13'h00cb, 0, 0, 8'h19, 8'h60},
        '{2, 13'h0640, 0, 0, 8'h7f, 0}, '{3, 13'h1fd8, 0, 0, 8'h00, 0},
        '{4, 13'h0010, 1, 0, 8'hff, 0}, '{5, 13'h0010, 0, 1, 8'hee, 0},
        '{6, 13'h03f8, 0, 0, 8'h7f, 0}, '{1, 13'h0010, 1, 0, 8'hff, 0},
        '{1, 13'h1ffc, 0, 0, 8'h00, 0}, '{1, 13'h03ff, 0, 0, 8'h7f, 8'he0}};
    logic clk_sys_i, nrst_i, ce_i, upd_i, upd_open_i, upd_short_i, scl, sda_pull, a;
    logic [2:0] upd_ch_i;
    logic [12:0] upd_temp_i;
    logic [7:0] cmd_ptr_o, cfg1_o, d;
    wire sda_o, sda_oe_o, hold_o;
    int n_mismatch = 0;
    int cmp_count = 0;
    // Open-drain wire with pull-up.
    wire sda = !(sda_oe_o || sda_pull);
    stp_smbus #(.TOUT_CYC(TOUT)) dut (.clk_sys_i(clk_sys_i), .nrst_i(nrst_i), .ce_i(ce_i),
        .scl_i(scl), .sda_i(sda), .sda_o(sda_o), .sda_oe_o(sda_oe_o), .upd_i(upd_i),
        .upd_ch_i(upd_ch_i), .upd_temp_i(upd_temp_i), .upd_open_i(upd_open_i),
        .upd_short_i(upd_short_i), .cmd_ptr_o(cmd_ptr_o), .cfg1_o(cfg1_o), .hold_o(hold_o));
    stp_host_model h (.clk_sys_i(clk_sys_i), .sda_line_i(sda), .scl_o(scl),
        .sda_pull_o(sda_pull));
    // Free-running 25 MHz clock.
    initial
    begin
        clk_sys_i = 1'b0;
        forever #20 clk_sys_i = !clk_sys_i;
    end
    task chk(input logic [7:0] s, input logic [7:0] e);
        cmp_count++;
        if (s !== e)
        begin
            n_mismatch++;
            $display("ERROR t=%0t seen=%h exp=%h", $time, s, e);
        end
    endtask
    task tally_and_finish;
        $display("checks=%0d mismatches=%0d", cmp_count, n_mismatch);
        if (n_mismatch == 0 && cmp_count > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask
    task sa(input logic rw);
        h.start;
        h.wr({`STP_SLAVE_ADDR, rw}, a);
        chk({7'h0, a}, 8'h01);
    endtask
    task recv(input logic [7:0] e);
        sa(1'b1);
        h.rd(1'b1, d);
        h.stop;
        chk({7'h0, h.r}, 8'h01);
        chk(d, e);
    endtask
    task cmd(input logic [7:0] c);
        sa(1'b0);
        h.wr(c, a);
        chk({7'h0, a}, 8'h01);
    endtask
    task wbyte(input logic [7:0] c, input logic [7:0] v);
        cmd(c);
        h.wr(v, a);
        h.stop;
        chk({7'h0, a}, 8'h01);
    endtask
    task rbyte(input logic [7:0] c, input logic [7:0] e);
        cmd(c);
        recv(e);
    endtask
    task upd(input logic [2:0] c, input logic [12:0] t, input logic o, input logic s);
        @(negedge clk_sys_i);
        {upd_i, upd_ch_i, upd_temp_i, upd_open_i, upd_short_i} = {1'b1, c, t, o, s};
        @(negedge clk_sys_i);
        upd_i = 1'b0;
    endtask
    // Main sequence: reset, table rows, then edge cases.
    initial
    begin
        {nrst_i, ce_i, upd_i, upd_ch_i, upd_temp_i, upd_open_i, upd_short_i} = 21'h080000;
        repeat (6) @(negedge clk_sys_i);
        nrst_i = 1'b1;
        chk(cmd_ptr_o | cfg1_o | {7'h0, hold_o}, 8'h00);
        chk({6'h0, sda_o, sda_oe_o}, 8'h00);
        recv(8'h00);
        for (int i = 0; i < 10; i++)
        begin
            upd(rows[i].ch, rows[i].t, rows[i].op, rows[i].sh);
            if (rows[i].ch == 3'h1)
                rbyte(8'h17, rows[i].ext);
            rbyte(8'h10 + {5'h0, rows[i].ch}, rows[i].hi);
        end
        wbyte(8'h05, 8'ha5);
        wbyte(8'h06, 8'h3c);
        cmd(8'h05);
        h.stop;
        chk(cmd_ptr_o, 8'h05);
        recv(8'ha5);
        rbyte(8'h06, 8'h3c);
        wbyte(8'h10, 8'h55);
        rbyte(8'h10, 8'h19);
        rbyte(8'h20, 8'h00);
        cmd(8'h07);
        h.wr(8'h11, a);
        h.wr(8'h22, a);
        h.stop;
        chk({7'h0, a}, 8'h00);
        rbyte(8'h07, 8'h11);
        h.start;
        h.wr({`STP_SLAVE_ADDR ^ 7'h01, 1'b0}, a);
        h.stop;
        chk({7'h0, a}, 8'h00);
        ce_i = 1'b0;
        upd(3'h0, 13'h0050, 0, 0);
        ce_i = 1'b1;
        rbyte(8'h10, 8'h19);
        upd(3'h1, 13'h0050, 0, 0);
        rbyte(8'h17, 8'h00);
        upd(3'h1, 13'h00a0, 0, 0);
        chk({7'h0, hold_o}, 8'h01);
        rbyte(8'h11, 8'h0a);
        chk({7'h0, hold_o}, 8'h00);
        rbyte(8'h17, 8'h00);
        repeat (TOUT + 10) @(negedge clk_sys_i);
        chk({7'h0, hold_o}, 8'h00);
        upd(3'h1, 13'h0140, 0, 0);
        rbyte(8'h11, 8'h28);
        wbyte(8'h01, 8'h20);
        chk(cfg1_o, 8'h20);
        rbyte(8'h17, 8'h00);
        repeat (TOUT + 10) @(negedge clk_sys_i);
        upd(3'h1, 13'h0190, 0, 0);
        chk({7'h0, hold_o}, 8'h01);
        rbyte(8'h11, 8'h28);
        chk({7'h0, hold_o}, 8'h00);
        tally_and_finish;
    end
    // Watchdog against a hung transfer.
    initial
    begin
        repeat (60000) @(posedge clk_sys_i);
        n_mismatch++;
        tally_and_finish;
    end
endmodule
